// File: ssi_transmitter.sv
/*
 * Encoder end of an SSI link: captures position plus special bit on the first
 * falling clock, shifts it out MSB first, holds data low for the hold-off time,
 * and repeats the word while clocking continues (ring mode).
 * Assumes ser_clk comes from the controller asynchronously; no other registers.
 */
`timescale 1ns/1ps
// Operation
// - Idle: clock and data lines both rest high.
// - First falling clock after idle captures position and special bit.
// - MSB appears on data at the first rising clock edge.
// - Each later rising edge presents the next lower bit until LSB.
// - After LSB, data held low until hold-off elapses, then high.
// - Hold-off interval starts at the last falling clock edge.
// - Word is n bits: singleturn plus multiturn resolution plus the special bit.
// - Continued clocking after the word resends the same stored word.
// - Pulse n+2 after hold-off starts fresh word, else repeats stored one.
module ssi_transmitter #(
	parameter int POS_BITS = ssi_pkg::SINGLETURN_BITS + ssi_pkg::MULTITURN_BITS,
	parameter int HOLD_CYCLES = ssi_pkg::HOLD_OFF_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic ser_clk,
	input wire logic [POS_BITS-1:0] position_bits,
	input wire logic special_bit,
	output logic ser_data,
	output logic busy
);
	import ssi_pkg::*;

	localparam int WORD_BITS = POS_BITS + SPECIAL_BITS;
	localparam int IDX_W = $clog2(WORD_BITS + 1);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(WORD_BITS - 1);
	localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD = HOLD_CNT_W'(HOLD_CYCLES);

	typedef enum logic [1:0] {SSI_IDLE, SSI_SHIFT, SSI_HOLD} ssi_state_e;

	// Bit of the stored word that goes out after a given number of bits sent
	function automatic logic word_bit(
		input logic [WORD_BITS-1:0] w,
		input logic [IDX_W-1:0] sent
	);
		return w[LAST_IDX - sent];
	endfunction

	ssi_state_e state_reg;
	logic [1:0] sclk_sync_reg;
	logic sclk_prev_reg;
	logic [WORD_BITS-1:0] word_reg;
	logic [IDX_W-1:0] bits_sent_reg;
	logic [HOLD_CNT_W-1:0] hold_cnt_reg;
	logic data_reg;
	logic sclk_s;
	logic fall_edge;
	logic rise_edge;
	logic hold_done;
	logic word_done;
	logic fresh_start;

	assign sclk_s = sclk_sync_reg[1];
	assign fall_edge = sclk_prev_reg & ~sclk_s;
	assign rise_edge = ~sclk_prev_reg & sclk_s;
	assign hold_done = hold_cnt_reg == '0;
	assign word_done = bits_sent_reg == IDX_W'(WORD_BITS);
	// Clocking resumed only after hold-off ran out: a new word is due
	assign fresh_start = state_reg == SSI_HOLD && fall_edge && hold_done;
	assign ser_data = data_reg;
	assign busy = state_reg != SSI_IDLE;

	// Clock pin is asynchronous to ref_clk; first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sclk_sync_reg <= {SSI_LINE_IDLE, SSI_LINE_IDLE};
			sclk_prev_reg <= SSI_LINE_IDLE;
		end else if (clk_en) begin
			sclk_sync_reg <= {sclk_sync_reg[0], ser_clk};
			sclk_prev_reg <= sclk_s;
		end
	end

	// Hold-off monoflop, retriggered by every falling edge so the last one counts
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hold_cnt_reg <= '0;
		end else if (clk_en) begin
			if (fall_edge) begin
				hold_cnt_reg <= HOLD_LOAD;
			end else if (!hold_done) begin
				hold_cnt_reg <= hold_cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= SSI_IDLE;
			word_reg <= '0;
			bits_sent_reg <= '0;
			data_reg <= SSI_LINE_IDLE;
		end else if (clk_en) begin
			unique case (state_reg)
				SSI_IDLE: begin
					data_reg <= SSI_LINE_IDLE;
					if (fall_edge) begin
						word_reg <= {position_bits, special_bit};
						bits_sent_reg <= '0;
						state_reg <= SSI_SHIFT;
					end
				end
				SSI_SHIFT: begin
					if (rise_edge && !word_done) begin
						data_reg <= word_bit(word_reg, bits_sent_reg);
						bits_sent_reg <= bits_sent_reg + 1'b1;
					end else if (fall_edge && word_done) begin
						// The fall after the LSB closes the word; data goes low and stays low through its rise
						data_reg <= SSI_LINE_LOW;
						state_reg <= SSI_HOLD;
					end
				end
				SSI_HOLD: begin
					// Data stays low; the closing rise is ignored, so only a further
					// falling edge means the controller keeps clocking
					if (fall_edge) begin
						if (hold_done) begin
							// Late pulse n+2: capture here, or the edge would be lost
							word_reg <= {position_bits, special_bit};
						end
						bits_sent_reg <= '0;
						state_reg <= SSI_SHIFT;
					end else if (hold_done) begin
						data_reg <= SSI_LINE_IDLE;
						state_reg <= SSI_IDLE;
					end
				end
				default: state_reg <= SSI_IDLE;
			endcase
		end
	end

	a_idle_data_high: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_IDLE && $past(state_reg) == SSI_IDLE |-> ser_data)
		else $error("data not high while idle");
	a_capture_word: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_IDLE && fall_edge |=>
		word_reg == {$past(position_bits), $past(special_bit)} && state_reg == SSI_SHIFT)
		else $error("word not captured on first falling edge");
	a_msb_first: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_SHIFT && rise_edge && bits_sent_reg == '0 |=>
		ser_data == word_reg[LAST_IDX])
		else $error("MSB not sent first");
	a_bit_advance: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_SHIFT && rise_edge && !word_done |=>
		bits_sent_reg == $past(bits_sent_reg) + 1'b1)
		else $error("bit index did not advance");
	a_low_after_lsb: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_HOLD |-> !ser_data)
		else $error("data not low during hold-off");
	a_hold_start: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && fall_edge |=> hold_cnt_reg == HOLD_LOAD)
		else $error("hold-off not started on falling edge");
	a_hold_release: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_HOLD && hold_done && !fall_edge |=>
		state_reg == SSI_IDLE && ser_data)
		else $error("data not released after hold-off");
	a_ring_repeat: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_HOLD && fall_edge && !hold_done |=>
		state_reg == SSI_SHIFT && $stable(word_reg) && bits_sent_reg == '0 && !ser_data)
		else $error("ring mode did not repeat stored word");
	a_word_stable: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg != SSI_IDLE && $past(state_reg) != SSI_IDLE && !$past(fresh_start)
		|-> $stable(word_reg))
		else $error("stored word changed mid transfer");

	// Word content and order, beyond the index bookkeeping
	a_bit_value: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_SHIFT && rise_edge && !word_done |=>
		ser_data == word_bit(word_reg, $past(bits_sent_reg)))
		else $error("wrong bit of the stored word sent");

	a_word_length: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_SHIFT |-> bits_sent_reg <= IDX_W'(WORD_BITS))
		else $error("more bits sent than the word holds");

	a_data_steady: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_SHIFT && !rise_edge && !fall_edge |=> $stable(ser_data))
		else $error("data moved without a clock edge");

	// Hold-off timing and the late pulse that starts a new word
	a_hold_count: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && !fall_edge && !hold_done |=>
		hold_cnt_reg == $past(hold_cnt_reg) - 1'b1)
		else $error("hold-off counter did not count down");

	a_hold_low: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && state_reg == SSI_HOLD && !hold_done && !fall_edge |=> !ser_data)
		else $error("data released before hold-off ended");

	a_fresh_word: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && fresh_start |=>
		word_reg == {$past(position_bits), $past(special_bit)} && state_reg == SSI_SHIFT)
		else $error("late pulse did not capture a new word");

	// A low enable must freeze state, data and the hold-off counter
	a_clk_freeze: assert property (@(posedge ref_clk) disable iff (reset)
		!clk_en |=> $stable(state_reg) && $stable(ser_data) && $stable(hold_cnt_reg))
		else $error("state moved while clock enable low");

	c_transfer: cover property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_HOLD ##1 state_reg == SSI_IDLE);
	c_ring: cover property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_HOLD ##1 state_reg == SSI_SHIFT);
	c_fresh: cover property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_IDLE && fall_edge);
	c_word_end: cover property (@(posedge ref_clk) disable iff (reset)
		state_reg == SSI_SHIFT && word_done && fall_edge);
	c_late_pulse: cover property (@(posedge ref_clk) disable iff (reset)
		fresh_start);
endmodule

// File: ssi_pkg.sv
/*
 * Constants for the SSI position transmitter: word sizes and hold-off timing.
 * Assumes a 125 MHz ref_clk that samples the controller's serial clock.
 */
package ssi_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SINGLETURN_BITS = 13;
	localparam int MULTITURN_BITS = 12;
	localparam int SPECIAL_BITS = 1;
	localparam int HOLD_OFF_NS = 20000;
	// Least time, rounded up to whole cycles
	localparam int HOLD_OFF_CYCLES = (HOLD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CNT_W = 16;
	localparam logic SSI_LINE_IDLE = 1'b1;
	localparam logic SSI_LINE_LOW = 1'b0;
endpackage

// File: ssi_ctrl_model.sv
/* Controller model: clocks SSI bundles into the transmitter and collects
   the returned bits. Assumes ser_data comes straight from the block. */
`timescale 1ns/1ps
module ssi_ctrl_model (
	output logic ser_clk,
	input wire logic ser_data
);
	logic [63:0] rx;
	initial ser_clk = 1'b1;
	// 64 ns period keeps far below the hold-off, so a long bundle rings
	// n pulses plus a closing one; n bits are taken, each in the following low phase
	task automatic bundle(input int n);
		rx = '0;
		for (int i = 0; i < n; i++) begin
			ser_clk = 1'b0;
			#16;
			if (i > 0) rx = {rx[62:0], ser_data};
			#16;
			ser_clk = 1'b1;
			#32;
		end
		ser_clk = 1'b0;
		#16;
		rx = {rx[62:0], ser_data};
		#16;
		ser_clk = 1'b1;
	endtask
endmodule

// File: test_ssi_transmitter.sv
/* Bench for the SSI transmitter: the controller model clocks words out and
   each task judges them. Assumes a short hold-off parameter. */
`timescale 1ns/1ps
module test_ssi_transmitter;
	import ssi_pkg::*;
	localparam int N = SINGLETURN_BITS + MULTITURN_BITS;
	localparam int HOLD = 40;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic special_bit = 1'b1;
	logic [N-1:0] position_bits = 25'h1A5C3E1;
	logic ser_clk;
	logic ser_data;
	logic busy;
	int fail_count = 0;
	int checks = 0;
	ssi_transmitter #(.HOLD_CYCLES(HOLD)) uut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.ser_clk(ser_clk), .position_bits(position_bits), .special_bit(special_bit),
		.ser_data(ser_data), .busy(busy));
	ssi_ctrl_model ctrl (.ser_clk(ser_clk), .ser_data(ser_data));
	initial forever #4 ref_clk = ~ref_clk;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Bundle ends 4 cycles after the last fall; hold-off counts from that fall
	task automatic hold_off();
		wait_cyc(8);
		check({busy, ser_data}, 2'b10);
		wait_cyc(HOLD - 18);
		check(ser_data, 1'b0);
		wait_cyc(18);
		check({busy, ser_data}, 2'b01);
	endtask
	// The word changes mid-bundle; only the one captured at the first fall may appear
	task automatic run(input int words);
		logic [63:0] word;
		word = {position_bits, special_bit};
		// Ring: one low separator bit, then the same word again
		if (words == 2) word = {word[N:0], 1'b0, word[N:0]};
		fork
			ctrl.bundle(words * (N + 2) - 1);
			begin
				wait_cyc(10);
				position_bits = ~position_bits;
			end
		join
		check(ctrl.rx, word);
		hold_off();
		$display("test of %0d word(s) done", words);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		check({busy, ser_data}, 2'b01);
		run(1);
		run(1); // Fresh word after the pause
		run(2);
		conclude();
	end
	initial begin
		#60000;
		fail_count++;
		conclude();
	end
endmodule
